// ### hw/aux_reg_indirect_agen.sv
// control-mode auxiliary pointer indirect address generation and update
// Contract
// [R1] operand set applies only while pointer mode select is one
// [R2] post-modify: address from old pointer, then add or subtract sign-extended index
// [R3] index is temp index zero when compat bit clear, extended pointer zero when set
// [R4] base-plus-index leaves pointer, address is pointer plus sign-extended index
// [R5] base-plus-index offset is extended pointer zero when compat set, else temp index
// [R6] base-plus-constant leaves pointer, address is pointer plus sign-extended constant
// [R7] pre-modify adds sign-extended constant first and uses updated pointer as address
// [R8] constant operand needs its two-byte extension word
// [R9] constant operand forms are never issued in parallel
// [R10] post-increment steps by one for word or bit, two for long or pair
// [R11] post-decrement steps by one for word or bit, two for long or pair
// [R12] single-bit access counts as one-bit, bit pair as two-bit
// [R13] all sums wrap modulo two to the twenty-third
module aux_reg_indirect_agen
    import agen_pkg::*;
#(
    parameter int NPTR = NUM_PTRS
) (
    input wire logic i_clk_sys,                      // cpu clock
    input wire logic i_reset,                        // async reset, high
    input wire logic i_req_valid,                    // operand request present
    input wire agen_req_t i_req,                     // decoded operand
    input wire logic i_pointer_mode_select,          // 1 selects control mode
    input wire logic i_compat_mode_bit,              // selects index source
    input wire logic [IDX_W-1:0] i_temp_index_zero,  // temporary index register
    input wire logic i_load_valid,                   // software pointer load
    input wire logic [SEL_W-1:0] i_load_sel,         // pointer being loaded
    input wire logic [PTR_W-1:0] i_load_value,       // loaded value
    output logic o_rsp_valid,                        // address valid, registered
    output agen_rsp_t o_rsp,                         // address and update, registered
    output logic o_reject,                           // request refused, registered
    output logic [NPTR*PTR_W-1:0] o_ptrs             // all extended pointers
);
    logic [PTR_W-1:0] ptr_r [NPTR];
    logic o_rsp_valid_nxt;
    agen_rsp_t rsp_r;
    agen_rsp_t rsp_nxt;
    logic reject_r;

    // decoder-side legality: constant forms need extension and no parallel slot
    function automatic logic is_const_op(input operand_t op);
        return (op == OP_BASE_CONST) || (op == OP_PRE_CONST);
    endfunction

    wire logic const_op = is_const_op(i_req.op);
    wire logic mode_ok = (i_pointer_mode_select == 1'(CONTROL_MODE)); // see [R1]
    wire logic const_bad = const_op && (!i_req.has_extension || i_req.parallel); // see [R8] see [R9]
    wire logic accept = i_req_valid && mode_ok && !const_bad;

    // operand sources
    wire logic [PTR_W-1:0] base = ptr_r[i_req.ptr_sel];
    logic [PTR_W-1:0] step;
    logic [PTR_W-1:0] temp_ext;
    logic [PTR_W-1:0] konst_ext;

    agen_step u_step_idx (
        .i_acc(i_req.acc),
        .i_index(i_temp_index_zero),
        .o_step(step),
        .o_index_ext(temp_ext)
    );
    agen_step u_step_const (
        .i_acc(i_req.acc),
        .i_index(i_req.long_offset_constant),
        .o_step(),
        .o_index_ext(konst_ext)
    );

    // extended pointer zero is already full width; temp index is sign-extended
    wire logic [PTR_W-1:0] index_sel = i_compat_mode_bit ? ptr_r[0] : temp_ext; // see [R3] see [R5]
    wire logic [PTR_W-1:0] sum_idx = base + index_sel;    // see [R13]
    wire logic [PTR_W-1:0] dif_idx = base - index_sel;    // see [R13]
    wire logic [PTR_W-1:0] sum_k = base + konst_ext;      // see [R6] see [R7]
    wire logic [PTR_W-1:0] inc_p = base + step;           // see [R10]
    wire logic [PTR_W-1:0] dec_p = base - step;           // see [R11]

    // address and new pointer per operand form
    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.ptr_sel = i_req.ptr_sel;
        rsp_nxt.addr = base;
        rsp_nxt.new_ptr = base;
        case (i_req.op)
            OP_PLAIN: begin
                rsp_nxt.write_back = 1'b0;
            end
            OP_POST_INC: begin
                rsp_nxt.new_ptr = inc_p;
                rsp_nxt.write_back = 1'b1;
            end
            OP_POST_DEC: begin
                rsp_nxt.new_ptr = dec_p;
                rsp_nxt.write_back = 1'b1;
            end
            OP_POST_ADD_IDX: begin
                rsp_nxt.new_ptr = sum_idx; // see [R2]
                rsp_nxt.write_back = 1'b1;
            end
            OP_POST_SUB_IDX: begin
                rsp_nxt.new_ptr = dif_idx; // see [R2]
                rsp_nxt.write_back = 1'b1;
            end
            OP_BASE_IDX: begin
                rsp_nxt.addr = sum_idx; // see [R4]
            end
            OP_BASE_CONST: begin
                rsp_nxt.addr = sum_k; // see [R6]
            end
            OP_PRE_CONST: begin
                rsp_nxt.addr = sum_k; // see [R7]
                rsp_nxt.new_ptr = sum_k;
                rsp_nxt.write_back = 1'b1;
            end
            default: begin
                rsp_nxt.write_back = 1'b0;
            end
        endcase
    end

    assign o_rsp_valid_nxt = accept;

    // pointer file; an operand update wins over a same-cycle software load
    // since the instruction stream is the later writer in program order
    generate
        for (genvar g = 0; g < NPTR; g++) begin : g_ptr
            wire logic upd = accept && rsp_nxt.write_back && (i_req.ptr_sel == SEL_W'(g));
            wire logic ld = i_load_valid && (i_load_sel == SEL_W'(g));
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    ptr_r[g] <= PTR_RESET;
                end else if (upd) begin
                    ptr_r[g] <= rsp_nxt.new_ptr;
                end else if (ld) begin
                    ptr_r[g] <= i_load_value;
                end
            end
            assign o_ptrs[g*PTR_W +: PTR_W] = ptr_r[g];
        end
    endgenerate

    // registered response
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_rsp_valid <= 1'b0;
            rsp_r <= '0;
            reject_r <= 1'b0;
        end else begin
            o_rsp_valid <= o_rsp_valid_nxt;
            rsp_r <= rsp_nxt;
            reject_r <= i_req_valid && !accept;
        end
    end
    assign o_rsp = rsp_r;
    assign o_reject = reject_r;

    // reference terms for the checks, built apart from the step helper so a broken extender shows
    wire logic [PTR_W-1:0] chk_temp_sx = {{(PTR_W-IDX_W){i_temp_index_zero[IDX_W-1]}}, i_temp_index_zero};
    wire logic [PTR_W-1:0] chk_const_sx =
        {{(PTR_W-IDX_W){i_req.long_offset_constant[IDX_W-1]}}, i_req.long_offset_constant};
    wire logic [PTR_W-1:0] chk_index = i_compat_mode_bit ? ptr_r[0] : chk_temp_sx;

    // assertions
    a_mode_gate: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R1]
        (i_req_valid && !i_pointer_mode_select) |=> (!o_rsp_valid && o_reject))
        else $error("request answered outside control mode");
    a_post_addr: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R2]
        (accept && i_req.op inside {OP_POST_INC, OP_POST_DEC, OP_POST_ADD_IDX, OP_POST_SUB_IDX})
        |=> (o_rsp.addr == $past(base)))
        else $error("post-modify address not from old pointer");
    a_post_add: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R3]
        (accept && i_req.op == OP_POST_ADD_IDX && !i_compat_mode_bit && i_req.ptr_sel != 0)
        |=> (ptr_r[$past(i_req.ptr_sel)] == PTR_W'($past(base) + $past(chk_temp_sx))))
        else $error("post-add by temp index wrong");
    a_post_sub: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R2]
        (accept && i_req.op == OP_POST_SUB_IDX)
        |=> (o_rsp.write_back && o_rsp.new_ptr == PTR_W'($past(base) - $past(chk_index))))
        else $error("post-subtract by index wrong");
    a_base_idx: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R4]
        (accept && i_req.op == OP_BASE_IDX)
        |=> (!o_rsp.write_back && o_rsp.addr == PTR_W'($past(base) + $past(chk_index))))
        else $error("base plus index wrong");
    a_compat_sel: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R5]
        (accept && i_req.op == OP_BASE_IDX && i_compat_mode_bit)
        |=> (o_rsp.addr == PTR_W'($past(base) + $past(ptr_r[0]))))
        else $error("compat index source wrong");
    a_base_const: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R6]
        (accept && i_req.op == OP_BASE_CONST)
        |=> (!o_rsp.write_back && o_rsp.addr == PTR_W'($past(base) + $past(chk_const_sx))))
        else $error("base plus constant wrong");
    a_base_keep: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R4] see [R6]
        (accept && i_req.op inside {OP_BASE_IDX, OP_BASE_CONST} && !i_load_valid)
        |=> (ptr_r[$past(i_req.ptr_sel)] == $past(base)))
        else $error("base form modified its pointer");
    a_pre_const: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R7]
        (accept && i_req.op == OP_PRE_CONST)
        |=> (o_rsp.addr == PTR_W'($past(base) + $past(chk_const_sx)) && o_rsp.addr == o_rsp.new_ptr && o_rsp.write_back))
        else $error("pre-modify address not the updated pointer");
    a_ptr_store: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R7]
        (accept && i_req.op inside {OP_POST_INC, OP_POST_DEC, OP_POST_ADD_IDX, OP_POST_SUB_IDX, OP_PRE_CONST})
        |=> (ptr_r[$past(i_req.ptr_sel)] == o_rsp.new_ptr))
        else $error("updated pointer not stored");
    a_refused_keep: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R1]
        (i_req_valid && !accept && !i_load_valid) |=> (o_ptrs == $past(o_ptrs)))
        else $error("refused request changed a pointer");
    a_const_legal: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R8] see [R9]
        (i_req_valid && const_op && (i_req.parallel || !i_req.has_extension)) |=> o_reject)
        else $error("illegal constant operand accepted");
    a_step_size: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R10] see [R12]
        (accept && i_req.op == OP_POST_INC)
        |=> (o_rsp.new_ptr - o_rsp.addr ==
            (($past(i_req.acc) inside {ACC_LONG, ACC_BIT_PAIR}) ? STEP_TWO : STEP_ONE)))
        else $error("increment step wrong");
    a_dec_step: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see [R11] see [R13]
        (accept && i_req.op == OP_POST_DEC)
        |=> (o_rsp.addr - o_rsp.new_ptr ==
            (($past(i_req.acc) inside {ACC_LONG, ACC_BIT_PAIR}) ? STEP_TWO : STEP_ONE)))
        else $error("decrement step wrong");

    c_post_inc: cover property (@(posedge i_clk_sys) disable iff (i_reset) accept && i_req.op == OP_POST_INC);
    c_post_sub_compat: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        accept && i_req.op == OP_POST_SUB_IDX && i_compat_mode_bit);
    c_pre_const: cover property (@(posedge i_clk_sys) disable iff (i_reset) accept && i_req.op == OP_PRE_CONST);
    c_compat_idx: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        accept && i_req.op == OP_BASE_IDX && i_compat_mode_bit);
    c_reject: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_reject);
endmodule

// ### common/agen_pkg.sv
// shared constants and types for the auxiliary pointer address generator
package agen_pkg;
    localparam int PTR_W = 23;
    localparam int IDX_W = 16;
    localparam int NUM_PTRS = 8;
    localparam int SEL_W = 3;
    localparam int EXT_BYTES = 2;
    localparam int CONTROL_MODE = 1;
    localparam logic [PTR_W-1:0] PTR_RESET = 23'h00_0000;
    localparam logic [PTR_W-1:0] STEP_ONE = 23'h00_0001;
    localparam logic [PTR_W-1:0] STEP_TWO = 23'h00_0002;

    // operand forms handled in control mode
    typedef enum logic [2:0] {
        OP_PLAIN = 3'h0,
        OP_POST_INC = 3'h1,
        OP_POST_DEC = 3'h2,
        OP_POST_ADD_IDX = 3'h3,
        OP_POST_SUB_IDX = 3'h4,
        OP_BASE_IDX = 3'h5,
        OP_BASE_CONST = 3'h6,
        OP_PRE_CONST = 3'h7
    } operand_t;

    // width class of the access
    typedef enum logic [1:0] {
        ACC_WORD = 2'h0,
        ACC_LONG = 2'h1,
        ACC_BIT = 2'h2,
        ACC_BIT_PAIR = 2'h3
    } access_t;

    typedef struct packed {
        operand_t op;
        access_t acc;
        logic [SEL_W-1:0] ptr_sel;
        logic [IDX_W-1:0] long_offset_constant;
        logic has_extension;
        logic parallel;
    } agen_req_t;

    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [PTR_W-1:0] new_ptr;
        logic [SEL_W-1:0] ptr_sel;
        logic write_back;
    } agen_rsp_t;
endpackage

// ### hw/agen_step.sv
// step size and sign extension helper for pointer arithmetic
module agen_step
    import agen_pkg::*;
(
    input wire access_t i_acc,               // access width class
    input wire logic [IDX_W-1:0] i_index,    // signed 16-bit value
    output logic [PTR_W-1:0] o_step,         // 1 or 2 by access width
    output logic [PTR_W-1:0] o_index_ext     // index sign-extended to pointer width
);
    // single bits count like words, bit pairs like longs
    wire logic is_wide = (i_acc == ACC_LONG) || (i_acc == ACC_BIT_PAIR); // see [R12]
    assign o_step = is_wide ? STEP_TWO : STEP_ONE; // see [R10] see [R11]
    assign o_index_ext = {{(PTR_W-IDX_W){i_index[IDX_W-1]}}, i_index}; // see [R2]
endmodule

// ### tb/agen_decoder_model.sv
// decoder-side model that issues operand requests to the address generator
module agen_decoder_model
    import agen_pkg::*;
(
    input wire logic i_clk_sys, // cpu clock
    output logic o_req_valid,   // request strobe
    output agen_req_t o_req     // decoded operand
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_req_valid = 1'b0;
        o_req = '0;
    end
    // launched just after the edge, held until the next one
    task automatic issue(input operand_t op, input access_t acc, input logic [2:0] sel, input logic [15:0] k,
                         input logic ext, input logic par);
        @(posedge i_clk_sys);
        #1;
        o_req_valid = 1'b1;
        o_req = '{op, acc, sel, k, ext, par};
    endtask
    // released request: scramble the constant so nothing stale looks valid
    task automatic idle();
        @(posedge i_clk_sys);
        #1;
        o_req_valid = 1'b0;
        o_req.long_offset_constant = ~o_req.long_offset_constant;
    endtask
endmodule

// ### tb/aux_reg_indirect_agen_test.sv
// self-checking bench for the auxiliary pointer address generator
module aux_reg_indirect_agen_test import agen_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, reset, req_valid, mode, compat, load_valid, rsp_valid, reject;
    agen_req_t req;
    agen_rsp_t rsp;
    logic [15:0] tidx;
    logic [2:0] load_sel;
    logic [22:0] load_value;
    logic [NUM_PTRS*PTR_W-1:0] ptrs;
    logic [22:0] ptr_m [8];
    logic [50:0] exp_q [$];
    logic [50:0] e;
    logic [50:0] g_rsp;
    int miscompares = 0;
    int n_tests = 0;

    aux_reg_indirect_agen dut (.i_clk_sys(clk_sys), .i_reset(reset), .i_req_valid(req_valid), .i_req(req),
        .i_pointer_mode_select(mode), .i_compat_mode_bit(compat), .i_temp_index_zero(tidx),
        .i_load_valid(load_valid), .i_load_sel(load_sel), .i_load_value(load_value),
        .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_reject(reject), .o_ptrs(ptrs));
    agen_decoder_model dec (.i_clk_sys(clk_sys), .o_req_valid(req_valid), .o_req(req));

    function automatic logic [22:0] sx(input logic [15:0] v);
        return {{7{v[15]}}, v};
    endfunction
    task automatic cmp_rsp(input logic [50:0] g, input logic [50:0] x);
        n_tests++;
        if (g !== x) begin
            $display("Error at %0t: response %h expected %h", $time, g, x);
            miscompares++;
        end
    endtask
    task automatic cmp_ptr(input logic [22:0] g, input logic [22:0] x);
        n_tests++;
        if (g !== x) begin
            $display("Error at %0t: pointer %h expected %h", $time, g, x);
            miscompares++;
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // reference result noted before the request goes out; mode and index bits change with it
    task automatic run(input operand_t op, input access_t acc, input logic [2:0] sel, input logic [15:0] k,
                       input logic ext, input logic par, input logic md);
        logic [22:0] p, ix, st, a, n;
        logic c, rej, wb;
        logic [15:0] t;
        c = 1'($urandom);
        t = 16'($urandom);
        p = ptr_m[sel];
        a = p;
        n = p;
        ix = c ? ptr_m[0] : sx(t);
        st = (acc == ACC_LONG || acc == ACC_BIT_PAIR) ? STEP_TWO : STEP_ONE;
        rej = !md || ((op == OP_BASE_CONST || op == OP_PRE_CONST) && (!ext || par));
        // only the post-modify and pre-modify forms write their pointer back
        wb = op inside {OP_POST_INC, OP_POST_DEC, OP_POST_ADD_IDX, OP_POST_SUB_IDX, OP_PRE_CONST};
        case (op)
            OP_POST_INC: n = p + st;
            OP_POST_DEC: n = p - st;
            OP_POST_ADD_IDX: n = p + ix;
            OP_POST_SUB_IDX: n = p - ix;
            OP_BASE_IDX: a = p + ix;
            OP_BASE_CONST: a = p + sx(k);
            OP_PRE_CONST: n = p + sx(k);
            default: ;
        endcase
        if (op == OP_PRE_CONST)
            a = n;
        if (!rej)
            ptr_m[sel] = n;
        exp_q.push_back(rej ? {1'b1, 50'h0} : {1'b0, a, n, sel, wb});
        dec.issue(op, acc, sel, k, ext, par);
        mode = md;
        compat = c;
        tidx = t;
    endtask
    // a load pulse with the request line quiet
    task automatic load(input logic [2:0] sel, input logic [22:0] v);
        dec.idle();
        load_valid = 1'b1;
        load_sel = sel;
        load_value = v;
        ptr_m[sel] = v;
        @(posedge clk_sys);
        #1;
        load_valid = 1'b0;
        load_value = ~v;
    endtask

    // results are looked at mid-cycle, where registered outputs are settled
    always @(negedge clk_sys) begin
        if (rsp_valid === 1'b1 || reject === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : '1;
            g_rsp = (reject === 1'b1) ? {1'b1, 50'h0} :
                {1'b0, rsp.addr, rsp.new_ptr, rsp.ptr_sel, rsp.write_back};
            cmp_rsp(g_rsp, e);
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end
    initial begin
        {reset, mode, compat, tidx, load_valid, load_sel, load_value} = {1'b1, 1'b1, 44'h0};
        foreach (ptr_m[i]) ptr_m[i] = PTR_RESET;
        void'($urandom(32'h0000_28be));
        repeat (2) @(posedge clk_sys);
        #1 reset = 1'b0;
        for (int i = 0; i < 8; i++) load(3'(i), 23'($urandom));
        // every form and width, back to back; parallel flag random
        repeat (6) for (int o = 0; o < 8; o++) for (int w = 0; w < 4; w++)
            run(operand_t'(o), access_t'(w), 3'($urandom), 16'($urandom), 1'b1, 1'($urandom), 1'b1);
        run(OP_POST_INC, ACC_WORD, 3'h2, 16'h0000, 1'b1, 1'b0, 1'b0);
        run(OP_BASE_CONST, ACC_WORD, 3'h2, 16'h8000, 1'b0, 1'b0, 1'b1);
        // wrap at both ends of the pointer range
        load(3'h5, 23'h7f_ffff);
        run(OP_POST_INC, ACC_BIT_PAIR, 3'h5, 16'h0000, 1'b1, 1'b0, 1'b1);
        run(OP_POST_DEC, ACC_LONG, 3'h5, 16'h0000, 1'b1, 1'b0, 1'b1);
        run(OP_PRE_CONST, ACC_BIT, 3'h5, 16'h0002, 1'b1, 1'b0, 1'b1);
        dec.idle();
        for (int i = 0; i < 8 && exp_q.size() > 0; i++) @(posedge clk_sys);
        if (exp_q.size() > 0)
            miscompares++;
        @(negedge clk_sys);
        for (int i = 0; i < 8; i++) cmp_ptr(ptrs[i*PTR_W +: PTR_W], ptr_m[i]);
        stop_test();
    end
endmodule
